/* File: common/bsb_pkg.sv */
package bsb_pkg;

  // ----------------------------------------
  // operation codes presented by the decoder
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_SKIP_REG_CLR = 5'h00,
    OP_SKIP_REG_SET = 5'h01,
    OP_SKIP_IO_CLR = 5'h02,
    OP_SKIP_IO_SET = 5'h03,
    OP_BR_FLAG_SET = 5'h04,
    OP_BR_FLAG_CLR = 5'h05,
    OP_BR_EQUAL = 5'h06,
    OP_BR_NOT_EQUAL = 5'h07,
    OP_BR_BORROW_SET = 5'h08,
    OP_BR_BORROW_CLR = 5'h09,
    OP_BR_SAME_HIGHER = 5'h0A,
    OP_BR_LOWER = 5'h0B,
    OP_BR_MINUS = 5'h0C,
    OP_BR_PLUS = 5'h0D,
    OP_BR_SIGNED_GE = 5'h0E,
    OP_BR_SIGNED_LT = 5'h0F,
    OP_BR_NIB_SET = 5'h10,
    OP_BR_NIB_CLR = 5'h11,
    OP_BR_USER_SET = 5'h12,
    OP_BR_USER_CLR = 5'h13,
    OP_BR_WRAP_SET = 5'h14,
    OP_BR_WRAP_CLR = 5'h15,
    OP_BR_IRQ_EN = 5'h16,
    OP_BR_IRQ_DIS = 5'h17,
    OP_IO_FORCE_ONE = 5'h18,
    OP_IO_FORCE_ZERO = 5'h19,
    OP_SHIFT_LEFT = 5'h1A,
    OP_SHIFT_RIGHT = 5'h1B
  } bsb_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } bsb_state_t;

  // ----------------------------------------
  // core flags register bit positions
  // ----------------------------------------
  localparam int FLAG_BORROW = 0;
  localparam int FLAG_NULL = 1;
  localparam int FLAG_MSB = 2;
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_NIB = 5;
  localparam int FLAG_USER = 6;
  localparam int FLAG_IRQ = 7;

  // ----------------------------------------
  // cycle counts and pc steps
  // ----------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
  localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
  localparam logic [1:0] CYC_IO_BIT = 2'h2;
  localparam int PC_STEP = 1;
  localparam int SKIP_STEP_ONE = 2;
  localparam int SKIP_STEP_TWO = 3;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bsb_pkg

/* File: rtl/bsb_cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none

module bsb_cond_eval (
  input wire bsb_pkg::bsb_op_t opCode,
  input wire logic [2:0] bitSel,
  input wire logic [7:0] flagsIn,
  input wire logic [7:0] regData,
  input wire logic [7:0] ioRdData,
  output logic condTrue,
  output logic isSkip,
  output logic isBranch
);

  // ----------------------------------------
  // condition selection
  // ----------------------------------------
  // pure decode so the condition is known in the accept cycle
  always_comb begin
    condTrue = 1'b0;
    isSkip = 1'b0;
    isBranch = 1'b1;
    case (opCode)
      bsb_pkg::OP_SKIP_REG_CLR: begin isSkip = 1'b1; isBranch = 1'b0; condTrue = ~regData[bitSel]; end
      bsb_pkg::OP_SKIP_REG_SET: begin isSkip = 1'b1; isBranch = 1'b0; condTrue = regData[bitSel]; end
      bsb_pkg::OP_SKIP_IO_CLR: begin isSkip = 1'b1; isBranch = 1'b0; condTrue = ~ioRdData[bitSel]; end
      bsb_pkg::OP_SKIP_IO_SET: begin isSkip = 1'b1; isBranch = 1'b0; condTrue = ioRdData[bitSel]; end
      bsb_pkg::OP_BR_FLAG_SET: condTrue = flagsIn[bitSel];
      bsb_pkg::OP_BR_FLAG_CLR: condTrue = ~flagsIn[bitSel];
      bsb_pkg::OP_BR_EQUAL: condTrue = flagsIn[bsb_pkg::FLAG_NULL];
      bsb_pkg::OP_BR_NOT_EQUAL: condTrue = ~flagsIn[bsb_pkg::FLAG_NULL];
      bsb_pkg::OP_BR_BORROW_SET, bsb_pkg::OP_BR_LOWER: condTrue = flagsIn[bsb_pkg::FLAG_BORROW];
      bsb_pkg::OP_BR_BORROW_CLR, bsb_pkg::OP_BR_SAME_HIGHER: condTrue = ~flagsIn[bsb_pkg::FLAG_BORROW];
      bsb_pkg::OP_BR_MINUS: condTrue = flagsIn[bsb_pkg::FLAG_MSB];
      bsb_pkg::OP_BR_PLUS: condTrue = ~flagsIn[bsb_pkg::FLAG_MSB];
      bsb_pkg::OP_BR_SIGNED_GE: condTrue = ~(flagsIn[bsb_pkg::FLAG_MSB] ^ flagsIn[bsb_pkg::FLAG_WRAP]);
      bsb_pkg::OP_BR_SIGNED_LT: condTrue = flagsIn[bsb_pkg::FLAG_MSB] ^ flagsIn[bsb_pkg::FLAG_WRAP];
      bsb_pkg::OP_BR_NIB_SET: condTrue = flagsIn[bsb_pkg::FLAG_NIB];
      bsb_pkg::OP_BR_NIB_CLR: condTrue = ~flagsIn[bsb_pkg::FLAG_NIB];
      bsb_pkg::OP_BR_USER_SET: condTrue = flagsIn[bsb_pkg::FLAG_USER];
      bsb_pkg::OP_BR_USER_CLR: condTrue = ~flagsIn[bsb_pkg::FLAG_USER];
      bsb_pkg::OP_BR_WRAP_SET: condTrue = flagsIn[bsb_pkg::FLAG_WRAP];
      bsb_pkg::OP_BR_WRAP_CLR: condTrue = ~flagsIn[bsb_pkg::FLAG_WRAP];
      bsb_pkg::OP_BR_IRQ_EN: condTrue = flagsIn[bsb_pkg::FLAG_IRQ];
      bsb_pkg::OP_BR_IRQ_DIS: condTrue = ~flagsIn[bsb_pkg::FLAG_IRQ];
      default: isBranch = 1'b0;
    endcase
  end

endmodule : bsb_cond_eval

`default_nettype wire

/* File: rtl/bsb_branch_skip_unit.sv */
// What this block does
// - skip on clear working-register bit, pc plus 2 or 3, flags kept.
// - skip on set working-register bit, pc plus 2 or 3, flags kept.
// - skip on clear I/O register bit, pc plus 2 or 3, flags kept.
// - skip on set I/O register bit, pc plus 2 or 3, flags kept.
// - branch when indexed flag is one, to pc plus offset plus one.
// - branch when indexed flag is zero, to pc plus offset plus one.
// - equal and not-equal branches follow the null result flag.
// - borrow set/lower and borrow clear/same-or-higher branches follow borrow flag.
// - minus and plus branches follow the msb result flag.
// - signed ge and lt branches follow msb xor wrap.
// - nibble carry branches follow the nibble carry flag.
// - user flag branches follow the spare user flag.
// - wrap branches follow the signed wrap flag.
// - interrupt-state branches follow the global unmask flag.
// - force one I/O bit, no flag change, two cycles.
// - force zero I/O bit, no flag change, two cycles.
// - logical shifts insert zero, update null, borrow, msb, wrap in one cycle.
`timescale 1ns/1ps
`default_nettype none

module bsb_branch_skip_unit #(
  parameter int PC_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic opValid,
  input wire bsb_pkg::bsb_op_t opCode,
  input wire logic [2:0] bitSel,
  input wire logic [6:0] offset,
  input wire logic nextTwoWord,
  input wire logic [PC_W-1:0] pcIn,
  input wire logic [7:0] regData,
  input wire logic [7:0] flagsIn,
  input wire logic [5:0] ioAddr,
  input wire logic [7:0] ioRdData,
  output logic opReady,
  output logic done,
  output logic pcLoad,
  output logic [PC_W-1:0] pcOut,
  output logic flagsWe,
  output logic [7:0] flagsOut,
  output logic regWe,
  output logic [7:0] regWrData,
  output logic ioWe,
  output logic [5:0] ioWrAddr,
  output logic [7:0] ioWrData
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [PC_W-1:0] pcPlus(input logic [PC_W-1:0] base, input int step);
    pcPlus = base + PC_W'(step);
  endfunction : pcPlus

  // 7-bit word displacement, sign extended so backward targets wrap correctly
  function automatic logic [PC_W-1:0] sext(input logic [6:0] k);
    sext = {{(PC_W-7){k[6]}}, k};
  endfunction : sext

  logic condTrue;
  logic isSkip;
  logic isBranch;
  logic opFire;
  logic [PC_W-1:0] brTarget;
  logic [7:0] bitMask;

  bsb_cond_eval u_cond (
    .opCode(opCode),
    .bitSel(bitSel),
    .flagsIn(flagsIn),
    .regData(regData),
    .ioRdData(ioRdData),
    .condTrue(condTrue),
    .isSkip(isSkip),
    .isBranch(isBranch)
  );

  assign brTarget = pcPlus(pcIn, bsb_pkg::PC_STEP) + sext(offset);
  assign bitMask = 8'h01 << bitSel;

  // ----------------------------------------
  // execution sequencer
  // ----------------------------------------
  bsb_pkg::bsb_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic ctrlOp_q, ctrlOp_d;
  logic done_q, done_d;
  logic pcLoad_q, pcLoad_d;
  logic [PC_W-1:0] pcOut_q, pcOut_d;
  logic flagsWe_q, flagsWe_d;
  logic [7:0] flagsOut_q, flagsOut_d;
  logic regWe_q, regWe_d;
  logic [7:0] regWr_q, regWr_d;
  logic ioWe_q, ioWe_d;
  logic [5:0] ioAddr_q, ioAddr_d;
  logic [7:0] ioWr_q, ioWr_d;
  logic taken_q, taken_d;
  logic ctrlEn_q;
  logic [1:0] cyc;
  logic [7:0] shRes;

  assign opReady = ctrlEn_q && (state_q == bsb_pkg::ST_IDLE);
  assign opFire = opValid && opReady;

  // next values: every op computes its result in the accept cycle and
  // the wait state only burns the documented extra cycles
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ctrlOp_d = ctrlOp_q;
    done_d = 1'b0;
    pcLoad_d = 1'b0;
    pcOut_d = pcOut_q;
    flagsWe_d = 1'b0;
    flagsOut_d = flagsOut_q;
    regWe_d = 1'b0;
    regWr_d = regWr_q;
    ioWe_d = 1'b0;
    ioAddr_d = ioAddr_q;
    ioWr_d = ioWr_q;
    taken_d = taken_q;
    cyc = bsb_pkg::CYC_ONE;
    shRes = 8'h00;
    case (state_q)
      bsb_pkg::ST_IDLE: begin
        if (opFire) begin
          ctrlOp_d = isSkip || isBranch;
          taken_d = (isSkip || isBranch) && condTrue;
          pcOut_d = pcPlus(pcIn, bsb_pkg::PC_STEP);
          if (isSkip && condTrue) begin
            cyc = nextTwoWord ? bsb_pkg::CYC_SKIP_TWO : bsb_pkg::CYC_SKIP_ONE;
            pcOut_d = pcPlus(pcIn, nextTwoWord ? bsb_pkg::SKIP_STEP_TWO : bsb_pkg::SKIP_STEP_ONE);
          end else if (isBranch && condTrue) begin
            cyc = bsb_pkg::CYC_BR_TAKEN;
            pcOut_d = brTarget;
          end else begin
            case (opCode)
              bsb_pkg::OP_IO_FORCE_ONE, bsb_pkg::OP_IO_FORCE_ZERO: begin
                // read-modify-write of one bit; flags are never touched here
                cyc = bsb_pkg::CYC_IO_BIT;
                ioWe_d = 1'b1;
                ioAddr_d = ioAddr;
                ioWr_d = (opCode == bsb_pkg::OP_IO_FORCE_ONE) ? (ioRdData | bitMask)
                                                              : (ioRdData & ~bitMask);
              end
              bsb_pkg::OP_SHIFT_LEFT, bsb_pkg::OP_SHIFT_RIGHT: begin
                // wrap is msb xor borrow after the shift; other flags pass through
                shRes = (opCode == bsb_pkg::OP_SHIFT_LEFT) ? {regData[6:0], 1'b0} : {1'b0, regData[7:1]};
                regWe_d = 1'b1;
                regWr_d = shRes;
                flagsWe_d = 1'b1;
                flagsOut_d = flagsIn;
                flagsOut_d[bsb_pkg::FLAG_NULL] = (shRes == 8'h00);
                flagsOut_d[bsb_pkg::FLAG_BORROW] = (opCode == bsb_pkg::OP_SHIFT_LEFT) ? regData[7] : regData[0];
                flagsOut_d[bsb_pkg::FLAG_MSB] = shRes[7];
                flagsOut_d[bsb_pkg::FLAG_WRAP] = shRes[7] ^ flagsOut_d[bsb_pkg::FLAG_BORROW];
              end
              default: ;
            endcase
          end
          if (cyc == bsb_pkg::CYC_ONE) begin
            done_d = 1'b1;
            pcLoad_d = isSkip || isBranch;
          end else begin
            state_d = bsb_pkg::ST_WAIT;
            cnt_d = cyc - bsb_pkg::CYC_ONE;
          end
        end
      end
      bsb_pkg::ST_WAIT: begin
        cnt_d = cnt_q - bsb_pkg::CYC_ONE;
        if (cnt_q == bsb_pkg::CYC_ONE) begin
          state_d = bsb_pkg::ST_IDLE;
          done_d = 1'b1;
          pcLoad_d = ctrlOp_q;
        end
      end
      default: state_d = bsb_pkg::ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= bsb_pkg::ST_IDLE;
      cnt_q <= 2'h0;
      ctrlOp_q <= 1'b0;
      done_q <= 1'b0;
      pcLoad_q <= 1'b0;
      pcOut_q <= '0;
      flagsWe_q <= 1'b0;
      flagsOut_q <= 8'h00;
      regWe_q <= 1'b0;
      regWr_q <= 8'h00;
      ioWe_q <= 1'b0;
      ioAddr_q <= 6'h00;
      ioWr_q <= 8'h00;
      taken_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ctrlOp_q <= ctrlOp_d;
      done_q <= done_d;
      pcLoad_q <= pcLoad_d;
      pcOut_q <= pcOut_d;
      flagsWe_q <= flagsWe_d;
      flagsOut_q <= flagsOut_d;
      regWe_q <= regWe_d;
      regWr_q <= regWr_d;
      ioWe_q <= ioWe_d;
      ioAddr_q <= ioAddr_d;
      ioWr_q <= ioWr_d;
      taken_q <= taken_d;
    end
  end

  assign done = done_q;
  assign pcLoad = pcLoad_q;
  assign pcOut = pcOut_q;
  assign flagsWe = flagsWe_q;
  assign flagsOut = flagsOut_q;
  assign regWe = regWe_q;
  assign regWrData = regWr_q;
  assign ioWe = ioWe_q;
  assign ioWrAddr = ioAddr_q;
  assign ioWrData = ioWr_q;

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [3:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic ctrlEn_d;
  logic [15:0] taken_cnt_q, taken_cnt_d;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rValid_q;

  // address and data may come in either order; the write lands once both are held
  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    bValid_d = bValid_q && !s_axi_bready;
    bResp_d = bResp_q;
    rValid_d = rValid_q && !s_axi_rready;
    rResp_d = rResp_q;
    rData_d = rData_q;
    ctrlEn_d = ctrlEn_q;
    // completed taken skips and branches counted; an increment beats a clear in the same cycle
    taken_cnt_d = taken_cnt_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      if (!s_axi_wstrb[0]) wData_d[0] = ctrlEn_q; // strobe only counts while wvalid is high
    end
    if (awHeld_q && wHeld_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = bsb_pkg::RESP_OKAY;
      if (awAddr_q == bsb_pkg::ADDR_CTRL) begin
        ctrlEn_d = wData_q[0];
      end else if (awAddr_q == bsb_pkg::ADDR_COUNT) begin
        taken_cnt_d = 16'h0000;
      end else if (awAddr_q != bsb_pkg::ADDR_STATUS) begin
        bResp_d = bsb_pkg::RESP_SLVERR;
      end
    end
    if (done_q && pcLoad_q && taken_q) begin
      taken_cnt_d = taken_cnt_q + 16'h0001;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_d = 1'b1;
      rResp_d = bsb_pkg::RESP_OKAY;
      rData_d = 32'h0000_0000;
      if (s_axi_araddr == bsb_pkg::ADDR_CTRL) begin
        rData_d[0] = ctrlEn_q;
      end else if (s_axi_araddr == bsb_pkg::ADDR_STATUS) begin
        rData_d[2:0] = {taken_q, state_q == bsb_pkg::ST_WAIT, opReady};
      end else if (s_axi_araddr == bsb_pkg::ADDR_COUNT) begin
        rData_d[15:0] = taken_cnt_q;
      end else begin
        rResp_d = bsb_pkg::RESP_SLVERR;
      end
    end
  end

  // slave registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q <= 32'h0000_0000;
      bValid_q <= 1'b0;
      bResp_q <= 2'h0;
      rValid_q <= 1'b0;
      rResp_q <= 2'h0;
      rData_q <= 32'h0000_0000;
      ctrlEn_q <= bsb_pkg::CTRL_EN_RST;
      taken_cnt_q <= 16'h0000;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
      ctrlEn_q <= ctrlEn_d;
      taken_cnt_q <= taken_cnt_d;
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = rData_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_skip_one;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_SKIP_REG_CLR && !regData[bitSel] && !nextTwoWord
      |=> !done ##1 (done && pcLoad && pcOut == $past(pcIn, 2) + PC_W'(2));
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("one-word skip wrong");

  property p_skip_two;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_SKIP_REG_SET && regData[bitSel] && nextTwoWord
      |=> (!done && !flagsWe) [*2] ##1 (done && pcOut == $past(pcIn, 3) + PC_W'(3));
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip wrong");

  property p_skip_io_not;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_SKIP_IO_CLR && ioRdData[bitSel]
      |=> done && !flagsWe && pcOut == $past(pcIn) + PC_W'(1);
  endproperty
  a_skip_io_not: assert property (p_skip_io_not) else $error("io skip taken wrongly");

  property p_br_taken;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_BR_FLAG_SET && flagsIn[bitSel]
      |=> !done ##1 (done && pcLoad && pcOut == $past(brTarget, 2));
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("flag branch target wrong");

  property p_br_ne_not;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_BR_NOT_EQUAL && flagsIn[bsb_pkg::FLAG_NULL]
      |=> done && pcOut == $past(pcIn) + PC_W'(1);
  endproperty
  a_br_ne_not: assert property (p_br_ne_not) else $error("untaken branch wrong");

  property p_br_sge;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_BR_SIGNED_GE
      && !(flagsIn[bsb_pkg::FLAG_MSB] ^ flagsIn[bsb_pkg::FLAG_WRAP]) |=> !done ##1 done;
  endproperty
  a_br_sge: assert property (p_br_sge) else $error("signed ge not taken");

  property p_io_one;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_IO_FORCE_ONE
      |=> (ioWe && ioWrData == ($past(ioRdData) | $past(bitMask)) && !done) ##1 (done && !ioWe);
  endproperty
  a_io_one: assert property (p_io_one) else $error("force one wrong");

  property p_io_zero;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_IO_FORCE_ZERO
      |=> ioWe && !flagsWe && ioWrData == ($past(ioRdData) & ~$past(bitMask)) && ioWrAddr == $past(ioAddr);
  endproperty
  a_io_zero: assert property (p_io_zero) else $error("force zero wrong");

  property p_shl;
    @(posedge clk) disable iff (rst)
    opFire && opCode == bsb_pkg::OP_SHIFT_LEFT
      |=> done && flagsWe && regWrData == {$past(regData[6:0]), 1'b0}
        && flagsOut[bsb_pkg::FLAG_BORROW] == $past(regData[7]);
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");

  c_skip_two: cover property (@(posedge clk) disable iff (rst) opFire && isSkip && condTrue && nextTwoWord);
  c_br_back: cover property (@(posedge clk) disable iff (rst) opFire && isBranch && condTrue && offset[6]);
  c_io_bit: cover property (@(posedge clk) disable iff (rst) ioWe);
  c_shr: cover property (@(posedge clk) disable iff (rst) opFire && opCode == bsb_pkg::OP_SHIFT_RIGHT);

endmodule : bsb_branch_skip_unit

`default_nettype wire

/* File: tb/bsb_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bsb_far_model (
  input wire logic clk,
  input wire logic [5:0] ioAddr,
  output logic [7:0] ioRdData,
  input wire logic ioWe,
  input wire logic [5:0] ioWrAddr,
  input wire logic [7:0] ioWrData
);
  logic [7:0] ioMem [64];

  // seeded with a fixed pattern so a read never returns an unknown
  initial begin
    for (int i = 0; i < 64; i++) ioMem[i] = 8'h5A ^ 8'(i * 37);
  end

  // reads are combinational, as the core's i/o space answers in the same cycle
  assign ioRdData = ioMem[ioAddr];

  // one write per strobe pulse
  always @(posedge clk) begin
    if (ioWe) ioMem[ioWrAddr] <= ioWrData;
  end
endmodule : bsb_far_model

`default_nettype wire

/* File: tb/tb_branch_skip_bitop_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_branch_skip_bitop_unit;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic opValid = 1'h0, nextTwoWord = 1'h0;
  bsb_pkg::bsb_op_t opCode = bsb_pkg::OP_SKIP_REG_CLR;
  logic [2:0] bitSel = 3'h0;
  logic [6:0] offset = 7'h0;
  logic [15:0] pcIn = 16'h0, pcOut;
  logic [7:0] regData = 8'h0, flagsIn = 8'h0, ioRdData, flagsOut, regWrData, ioWrData;
  logic [5:0] ioAddr = 6'h0, ioWrAddr;
  logic opReady, done, pcLoad, flagsWe, regWe, ioWe;
  int n_fail = 0, total_checks = 0, takenCnt = 0;

  bsb_branch_skip_unit #(.PC_W(16)) bsb_branch_skip_unit_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .opValid, .opCode, .bitSel, .offset, .nextTwoWord, .pcIn, .regData, .flagsIn, .ioAddr,
    .ioRdData, .opReady, .done, .pcLoad, .pcOut, .flagsWe, .flagsOut, .regWe, .regWrData, .ioWe, .ioWrAddr,
    .ioWrData);
  bsb_far_model bsb_far_model_inst (.clk, .ioAddr, .ioRdData, .ioWe, .ioWrAddr, .ioWrData);

  // free-running 200 MHz clock
  always #2.5 clk = ~clk;

  // -------------------------------------------
  // checking and bus helpers
  // -------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // address and data offered together, each dropped at its own handshake
  task automatic axiWr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // no cycle count assumed: bvalid ends this wait, and only the hang guard bounds it
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : axiWr

  task automatic axiRd(logic [3:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : axiRd

  // condition of every skip and branch code, worked out from the flag layout
  function automatic logic condOf(logic [4:0] c, logic [2:0] b, logic [7:0] f, logic [7:0] r, logic [7:0] io);
    case (c)
      5'h00: return !r[b];
      5'h01: return r[b];
      5'h02: return !io[b];
      5'h03: return io[b];
      5'h04: return f[b];
      5'h05: return !f[b];
      5'h06, 5'h07: return f[1] ^ c[0];
      5'h08, 5'h09: return f[0] ^ c[0];
      5'h0A, 5'h0B: return f[0] ^ !c[0];
      5'h0C, 5'h0D: return f[2] ^ c[0];
      5'h0E, 5'h0F: return f[2] ^ f[3] ^ !c[0];
      5'h10, 5'h11: return f[5] ^ c[0];
      5'h12, 5'h13: return f[6] ^ c[0];
      5'h14, 5'h15: return f[3] ^ c[0];
      default: return f[7] ^ c[0];
    endcase
  endfunction : condOf

  // one operation with random operands; cycles counted from the accept edge
  task automatic doOp(logic [4:0] c, logic [2:0] b, logic [6:0] off, logic two);
    logic cnd, co, sawIo, sawFw;
    logic [7:0] io0, res;
    logic [15:0] ePc;
    int n, eN;
    @(posedge clk);
    opValid <= 1'h1;
    opCode <= bsb_pkg::bsb_op_t'(c);
    bitSel <= b;
    offset <= off;
    nextTwoWord <= two;
    pcIn <= 16'($urandom);
    regData <= 8'($urandom);
    flagsIn <= 8'($urandom);
    ioAddr <= 6'($urandom);
    do @(negedge clk); while (opReady !== 1'h1);
    io0 = ioRdData;
    cnd = condOf(c, b, flagsIn, regData, io0);
    @(posedge clk);
    opValid <= 1'h0;
    n = 0;
    sawIo = 1'h0;
    sawFw = 1'h0;
    do begin @(negedge clk); n++; sawIo |= ioWe; sawFw |= flagsWe; end while (done !== 1'h1 && n < 8);
    eN = (c < 4) ? (cnd ? (two ? 3 : 2) : 1) : (c < 24) ? (cnd ? 2 : 1) : (c < 26) ? 2 : 1;
    ePc = pcIn + 16'h1;
    if (cnd && c < 4) ePc = pcIn + (two ? 16'h3 : 16'h2);
    if (cnd && c >= 4) ePc = pcIn + 16'h1 + {{9{off[6]}}, off};
    chk("cycles", 32'(n), 32'(eN));
    if (c < 24) begin
      takenCnt += cnd;
      chk("pcLoad", 32'(pcLoad), 32'h1);
      chk("pcOut", 32'(pcOut), 32'(ePc));
    end
    if (c < 26) chk("flagsWe", 32'(sawFw), 32'h0);
    if (c == 24 || c == 25) begin
      res = c[0] ? (io0 & ~(8'h1 << b)) : (io0 | (8'h1 << b));
      chk("ioWe", 32'(sawIo), 32'h1);
      chk("ioWrAddr", 32'(ioWrAddr), 32'(ioAddr));
      chk("ioWrData", 32'(ioWrData), 32'(res));
      chk("ioMem", 32'(ioRdData), 32'(res));
    end
    if (c >= 26) begin
      res = c[0] ? (regData >> 1) : (regData << 1);
      co = c[0] ? regData[0] : regData[7];
      chk("regWe", 32'(regWe), 32'h1);
      chk("flagsWe", 32'(flagsWe), 32'h1);
      chk("regWrData", 32'(regWrData), 32'(res));
      chk("flagsOut", 32'(flagsOut), 32'({flagsIn[7:4], res[7] ^ co, res[7], res == 8'h0, co}));
    end
  endtask : doOp

  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial begin
    void'($urandom(98));
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    axiRd(bsb_pkg::ADDR_CTRL, 32'h1, bsb_pkg::RESP_OKAY);
    axiRd(bsb_pkg::ADDR_STATUS, 32'h1, bsb_pkg::RESP_OKAY);
    axiRd(4'hC, 32'h0, bsb_pkg::RESP_SLVERR);
    axiWr(bsb_pkg::ADDR_CTRL, 32'h0, bsb_pkg::RESP_OKAY);
    @(negedge clk);
    chk("opReady", 32'(opReady), 32'h0);
    axiWr(bsb_pkg::ADDR_CTRL, 32'h1, bsb_pkg::RESP_OKAY);
    // every code with the extreme displacements, then a random mix
    for (int k = 0; k < 84; k++) begin
      doOp(5'(k % 28), 3'($urandom), (k < 28) ? 7'h40 : (k < 56) ? 7'h3F : 7'($urandom), 1'(k / 28 == 1));
    end
    repeat (200) doOp(5'($urandom_range(27)), 3'($urandom), 7'($urandom), 1'($urandom));
    axiRd(bsb_pkg::ADDR_COUNT, 32'(takenCnt), bsb_pkg::RESP_OKAY);
    axiWr(bsb_pkg::ADDR_COUNT, 32'h0, bsb_pkg::RESP_OKAY);
    axiRd(bsb_pkg::ADDR_COUNT, 32'h0, bsb_pkg::RESP_OKAY);
    axiWr(bsb_pkg::ADDR_STATUS, 32'h0, bsb_pkg::RESP_OKAY);
    results;
  end

  // hang guard at 40000 cycles, well beyond the under one thousand cycles the sequence needs
  initial begin
    #200000;
    n_fail++;
    results;
  end
endmodule : tb_branch_skip_bitop_unit

`default_nettype wire
